// *** hw/ida_indirect.sv ***
// indirect data addressing unit: pointers, working and bank registers
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps

// How it works
// - virtual locations address memory through selected pointer
// - post-increment: use pointer, then add one
// - post-decrement: use pointer, then subtract one
// - pre-increment: add one, then use pointer
// - plus-working: address is pointer plus working offset
// - pointers: full low byte, four-bit high byte
// - unimplemented bits read back as zero
module ida_indirect (
  input  wire logic       CLK,
  input  wire logic       RST_N,
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  output logic      [11:0] DMEM_ADDR,
  output logic      [7:0] DMEM_WDATA,
  output logic            DMEM_WE,
  output logic            DMEM_RE,
  input  wire logic [7:0] DMEM_RDATA,
  output logic      [3:0] BANK_SEL,
  output logic      [7:0] WORKING
);

  // =========================================================
  // state and decode signals
  ida_pkg::ida_state_s s_q;
  ida_pkg::ida_state_s s_d;
  logic        virt_hit;
  logic [1:0]  v_sel;
  logic [2:0]  v_kind;
  logic [4:0]  v_grp;
  logic [11:0] v_cur;
  logic [11:0] v_inc;
  logic [11:0] v_dec;
  logic [11:0] v_off;
  logic [11:0] v_addr;

  // =========================================================
  // next state, register access and pointer arithmetic
  always_comb begin
    s_d        = s_q;
    s_d.rdata  = 8'h00;
    s_d.rd_mem = 1'b0;
    v_grp      = ADDR[ida_pkg::ADDR_W-1:ida_pkg::GRP_LSB];
    v_kind     = ADDR[ida_pkg::GRP_LSB-1:0];
    // groups 1..3 map onto pointers a..c; other kinds are unmapped
    virt_hit   = (RD | WR) && (v_grp >= ida_pkg::GRP_PTR_A) &&
                 (v_grp <= ida_pkg::GRP_PTR_C) && (v_kind <= ida_pkg::LOC_PLUS_W);
    v_sel      = 2'(v_grp - ida_pkg::GRP_PTR_A);
    if (v_sel > 2'(ida_pkg::NPTR - 1)) begin
      v_sel = 2'h0;
    end
    v_cur = s_q.ptr[v_sel];
    v_inc = v_cur + ida_pkg::PTR_ONE;
    v_dec = v_cur - ida_pkg::PTR_ONE;
    // working register is a signed offset; wraps within 12 bits
    v_off = {{(ida_pkg::PTR_W-ida_pkg::DATA_W){s_q.working_register[7]}}, s_q.working_register};
    case (v_kind)
      ida_pkg::LOC_PRE_INC: begin
        v_addr = v_inc;
      end
      ida_pkg::LOC_PLUS_W: begin
        v_addr = v_cur + v_off;
      end
      default: begin
        v_addr = v_cur;
      end
    endcase

    if (virt_hit) begin
      // memory supplies read data in the following cycle
      s_d.rd_mem = RD;
      case (v_kind)
        ida_pkg::LOC_POST_INC: begin
          s_d.ptr[v_sel] = v_inc;
        end
        ida_pkg::LOC_POST_DEC: begin
          s_d.ptr[v_sel] = v_dec;
        end
        ida_pkg::LOC_PRE_INC: begin
          s_d.ptr[v_sel] = v_inc;
        end
        default: begin
          s_d.ptr[v_sel] = v_cur;
        end
      endcase
    end else if (WR) begin
      // high bytes keep only four bits; upper nibble is dropped
      case (ADDR)
        ida_pkg::OFS_P0_HIGH: s_d.ptr[0][11:8] = WDATA[3:0];
        ida_pkg::OFS_P0_LOW:  s_d.ptr[0][7:0]  = WDATA;
        ida_pkg::OFS_WORKING: s_d.working_register         = WDATA;
        ida_pkg::OFS_P1_HIGH: s_d.ptr[1][11:8] = WDATA[3:0];
        ida_pkg::OFS_P1_LOW:  s_d.ptr[1][7:0]  = WDATA;
        ida_pkg::OFS_BANK_SEL: s_d.bank_select         = WDATA[3:0];
        ida_pkg::OFS_P2_HIGH: s_d.ptr[2][11:8] = WDATA[3:0];
        ida_pkg::OFS_P2_LOW:  s_d.ptr[2][7:0]  = WDATA;
        default: begin
          s_d.working_register = s_q.working_register;
        end
      endcase
    end else if (RD) begin
      // unmapped addresses read zero
      case (ADDR)
        ida_pkg::OFS_P0_HIGH: s_d.rdata = {4'h0, s_q.ptr[0][11:8]};
        ida_pkg::OFS_P0_LOW:  s_d.rdata = s_q.ptr[0][7:0];
        ida_pkg::OFS_WORKING: s_d.rdata = s_q.working_register;
        ida_pkg::OFS_P1_HIGH: s_d.rdata = {4'h0, s_q.ptr[1][11:8]};
        ida_pkg::OFS_P1_LOW:  s_d.rdata = s_q.ptr[1][7:0];
        ida_pkg::OFS_BANK_SEL: s_d.rdata = {4'h0, s_q.bank_select};
        ida_pkg::OFS_P2_HIGH: s_d.rdata = {4'h0, s_q.ptr[2][11:8]};
        ida_pkg::OFS_P2_LOW:  s_d.rdata = s_q.ptr[2][7:0];
        default: begin
          s_d.rdata = 8'h00;
        end
      endcase
    end
  end

  // =========================================================
  // state register, synchronous reset
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      s_q.ptr    <= {ida_pkg::PTR_RST, ida_pkg::PTR_RST, ida_pkg::PTR_RST};
      s_q.working_register   <= ida_pkg::WORKING_REGISTER_RST;
      s_q.bank_select    <= ida_pkg::BSR_RST;
      s_q.rdata  <= 8'h00;
      s_q.rd_mem <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // =========================================================
  // outputs; memory strobes are combinational handshake
  assign DMEM_ADDR  = virt_hit ? v_addr : 12'h000;
  assign DMEM_WDATA = WDATA;
  assign DMEM_WE    = virt_hit & WR;
  assign DMEM_RE    = virt_hit & RD;
  // a virtual read has no storage here, so memory data is forwarded
  assign RDATA      = s_q.rd_mem ? DMEM_RDATA : s_q.rdata;
  assign BANK_SEL   = s_q.bank_select;
  assign WORKING    = s_q.working_register;

  // =========================================================
  // assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  AST_PLAIN_ADDR: assert property (
    (virt_hit && v_kind == ida_pkg::LOC_PLAIN) |-> (DMEM_ADDR == v_cur))
    else $error("plain location did not use pointer");

  AST_PLAIN_KEEP: assert property (
    (virt_hit && v_kind == ida_pkg::LOC_PLAIN) |=> (s_q.ptr == $past(s_q.ptr)))
    else $error("plain location changed a pointer");

  AST_POST_INC: assert property (
    (virt_hit && v_kind == ida_pkg::LOC_POST_INC) |->
      (DMEM_ADDR == v_cur) ##1 (s_q.ptr[$past(v_sel)] == 12'($past(DMEM_ADDR) + 12'h001)))
    else $error("post increment wrong");

  AST_POST_DEC: assert property (
    (virt_hit && v_kind == ida_pkg::LOC_POST_DEC) |->
      (DMEM_ADDR == v_cur) ##1 (s_q.ptr[$past(v_sel)] == 12'($past(DMEM_ADDR) - 12'h001)))
    else $error("post decrement wrong");

  AST_PRE_INC: assert property (
    (virt_hit && v_kind == ida_pkg::LOC_PRE_INC) |->
      (DMEM_ADDR == 12'(v_cur + 12'h001)) ##1 (s_q.ptr[$past(v_sel)] == $past(DMEM_ADDR)))
    else $error("pre increment wrong");

  AST_PLUS_W: assert property (
    (virt_hit && v_kind == ida_pkg::LOC_PLUS_W) |->
      (DMEM_ADDR == 12'(v_cur + {{4{WORKING[7]}}, WORKING})) ##1
      (s_q.ptr == $past(s_q.ptr)))
    else $error("plus working address wrong");

  AST_HIGH_ZERO: assert property (
    (RD && (ADDR == ida_pkg::OFS_P0_HIGH || ADDR == ida_pkg::OFS_P1_HIGH ||
            ADDR == ida_pkg::OFS_P2_HIGH || ADDR == ida_pkg::OFS_BANK_SEL))
      |=> (RDATA[7:4] == 4'h0))
    else $error("unimplemented bits read nonzero");

  AST_HIGH_STORE: assert property (
    (WR && ADDR == ida_pkg::OFS_P1_HIGH) ##1 (RD && ADDR == ida_pkg::OFS_P1_HIGH)
      |=> (RDATA == {4'h0, $past(WDATA[3:0], 2)}))
    else $error("pointer high byte not stored in four bits");

  AST_LOW_STORE: assert property (
    (WR && ADDR == ida_pkg::OFS_P2_LOW) ##1 (RD && ADDR == ida_pkg::OFS_P2_LOW)
      |=> (RDATA == $past(WDATA, 2)))
    else $error("pointer low byte not stored");

  AST_BSR_RESET: assert property (disable iff (1'b0)
    !RST_N |=> (BANK_SEL == ida_pkg::BSR_RST))
    else $error("bank select not cleared by reset");

  AST_VREAD_DATA: assert property (
    (virt_hit && RD) |=> (RDATA == DMEM_RDATA))
    else $error("virtual read data not forwarded");

  // =========================================================
  // strobe decode and register side effects
  // decode is rewritten from the address bits, not from virt_hit,
  // so a broken hit term cannot hide behind its own expression

  AST_WE_ONLY_VIRT: assert property (
    DMEM_WE |-> (WR && (ADDR[7:3] inside {[ida_pkg::GRP_PTR_A:ida_pkg::GRP_PTR_C]})
                 && (ADDR[2:0] <= ida_pkg::LOC_PLUS_W)))
    else $error("memory write strobe outside a virtual location");

  AST_RE_ONLY_VIRT: assert property (
    DMEM_RE |-> (RD && (ADDR[7:3] inside {[ida_pkg::GRP_PTR_A:ida_pkg::GRP_PTR_C]})
                 && (ADDR[2:0] <= ida_pkg::LOC_PLUS_W)))
    else $error("memory read strobe outside a virtual location");

  AST_ONE_MEM_STROBE: assert property (
    !(DMEM_WE && DMEM_RE))
    else $error("memory read and write strobes together");

  AST_IDLE_ADDR: assert property (
    (!RD && !WR) |-> (DMEM_ADDR == 12'h000))
    else $error("memory address not parked while idle");

  AST_WDATA_PASS: assert property (
    DMEM_WE |-> (DMEM_WDATA == WDATA))
    else $error("memory write data differs from bus data");

  AST_VIRT_NO_STORE: assert property (
    virt_hit |=> (WORKING == $past(WORKING) && BANK_SEL == $past(BANK_SEL)))
    else $error("virtual access changed a physical register");

  AST_INC_WRAP: assert property (
    (virt_hit && v_kind == ida_pkg::LOC_POST_INC && v_cur == 12'hfff) |=>
      (s_q.ptr[$past(v_sel)] == 12'h000))
    else $error("post increment did not wrap to zero");

  AST_DEC_WRAP: assert property (
    (virt_hit && v_kind == ida_pkg::LOC_POST_DEC && v_cur == 12'h000) |=>
      (s_q.ptr[$past(v_sel)] == 12'hfff))
    else $error("post decrement did not wrap to all ones");

  AST_PLUS_W_KEEP_W: assert property (
    (virt_hit && v_kind == ida_pkg::LOC_PLUS_W) |=> (WORKING == $past(WORKING)))
    else $error("plus working access changed the offset");

  AST_WORKING_STORE: assert property (
    (WR && ADDR == ida_pkg::OFS_WORKING) |=> (WORKING == $past(WDATA)))
    else $error("working register not written");

  AST_HIGH_MASK: assert property (
    (WR && ADDR == ida_pkg::OFS_P0_HIGH) |=>
      (s_q.ptr[0] == {$past(WDATA[3:0]), $past(s_q.ptr[0][7:0])}))
    else $error("high byte write disturbed the low byte");

  AST_LOW_KEEP_HIGH: assert property (
    (WR && ADDR == ida_pkg::OFS_P0_LOW) |=>
      (s_q.ptr[0] == {$past(s_q.ptr[0][11:8]), $past(WDATA)}))
    else $error("low byte write disturbed the high byte");

  // unmapped writes must be dropped, not folded onto a nearby register
  AST_UNMAPPED_KEEP: assert property (
    (WR && !virt_hit && ADDR > ida_pkg::OFS_P2_LOW) |=>
      (s_q.ptr == $past(s_q.ptr) && WORKING == $past(WORKING)
       && BANK_SEL == $past(BANK_SEL)))
    else $error("unmapped write changed a register");

  AST_UNMAPPED_ZERO: assert property (
    (RD && !virt_hit && ADDR > ida_pkg::OFS_P2_LOW) |=> (RDATA == 8'h00))
    else $error("unmapped read returned nonzero");

  AST_RDATA_IDLE: assert property (
    !RD |=> (RDATA == 8'h00))
    else $error("read data not zero outside the answer cycle");

  AST_RDATA_RESET: assert property (disable iff (1'b0)
    !RST_N |=> (RDATA == 8'h00))
    else $error("read data not cleared by reset");

  AST_BSR_STORE: assert property (
    (WR && ADDR == ida_pkg::OFS_BANK_SEL) |=> (BANK_SEL == $past(WDATA[3:0])))
    else $error("bank select not written in four bits");

  COV_POST_INC: cover property (virt_hit && WR && v_kind == ida_pkg::LOC_POST_INC);
  COV_PRE_INC:  cover property (virt_hit && RD && v_kind == ida_pkg::LOC_PRE_INC);
  COV_PLUS_W:   cover property (virt_hit && RD && v_kind == ida_pkg::LOC_PLUS_W
                                && WORKING[7]);
  COV_DEC_WRAP: cover property (virt_hit && v_kind == ida_pkg::LOC_POST_DEC
                                && v_cur == 12'h000);
  // back to back write of pointer 1 high byte, then a read at any address
  COV_WR_RD:    cover property ((WR && ADDR == ida_pkg::OFS_P1_HIGH) ##1 RD);

endmodule

// *** hw/ida_pkg.sv ***
// constants and state layout for the indirect data addressing unit
package ida_pkg;
  // =========================================================
  // widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PTR_W  = 12;
  localparam int unsigned HI_W   = 4;
  localparam int unsigned BSR_W  = 4;
  localparam int unsigned NPTR   = 3;

  // =========================================================
  // physical register offsets
  localparam logic [7:0] OFS_P0_HIGH  = 8'h00;
  localparam logic [7:0] OFS_P0_LOW   = 8'h01;
  localparam logic [7:0] OFS_WORKING  = 8'h02;
  localparam logic [7:0] OFS_P1_HIGH  = 8'h03;
  localparam logic [7:0] OFS_P1_LOW   = 8'h04;
  localparam logic [7:0] OFS_BANK_SEL = 8'h05;
  localparam logic [7:0] OFS_P2_HIGH  = 8'h06;
  localparam logic [7:0] OFS_P2_LOW   = 8'h07;

  // =========================================================
  // virtual locations: group in addr[7:3], kind in addr[2:0]
  localparam logic [4:0] GRP_PTR_A = 5'h01;
  localparam logic [4:0] GRP_PTR_C = 5'h03;
  localparam int unsigned GRP_LSB  = 3;
  localparam logic [2:0] LOC_PLAIN    = 3'h0;
  localparam logic [2:0] LOC_POST_INC = 3'h1;
  localparam logic [2:0] LOC_POST_DEC = 3'h2;
  localparam logic [2:0] LOC_PRE_INC  = 3'h3;
  localparam logic [2:0] LOC_PLUS_W   = 3'h4;

  // =========================================================
  // reset values and pointer step
  localparam logic [11:0] PTR_RST  = 12'h000;
  localparam logic [7:0]  WORKING_REGISTER_RST = 8'h00;
  localparam logic [3:0]  BSR_RST  = 4'h0;
  localparam logic [11:0] PTR_ONE  = 12'h001;

  // complete block state
  typedef struct packed {
    logic [2:0][11:0] ptr;
    logic [7:0]       working_register;
    logic [3:0]       bank_select;
    logic [7:0]       rdata;
    logic             rd_mem;
  } ida_state_s;
endpackage

// *** dv/ida_dmem_model.sv ***
// data memory model on the far side of the indirect unit
`timescale 1ns/1ps

module ida_dmem_model (
  input  wire logic        CLK,
  input  wire logic [11:0] ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WE,
  input  wire logic        RE,
  output logic      [7:0]  RDATA
);
  logic [7:0] mem [4096];
  logic [7:0] last_q = 8'h00;
  logic       vld_q  = 1'b0;

  // =====
  // storage; a read answers in the cycle after its strobe
  always_ff @(posedge CLK) begin
    if (WE) begin
      mem[ADDR] <= WDATA;
    end
    vld_q <= RE;
    if (RE) begin
      last_q <= mem[ADDR];
    end
  end

  // outside the answer cycle show the inverse, so stale data never matches
  assign RDATA = vld_q ? last_q : ~last_q;
endmodule

// *** dv/test_ida_indirect.sv ***
// self-checking bench for the indirect data addressing unit
`timescale 1ns/1ps

module test_ida_indirect;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [7:0]  wd = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  rdata;
  logic [11:0] dmem_addr;
  logic [7:0]  dmem_wdata;
  logic        dmem_we;
  logic        dmem_re;
  logic [7:0]  dmem_rdata;
  logic [3:0]  bank_sel;
  logic [7:0]  working;
  logic [7:0]  ha;
  logic [7:0]  va;
  logic [11:0] p;
  int          err_count = 0;
  int          n_compared = 0;

  ida_indirect ida_indirect_i (
    .CLK(clk), .RST_N(rst_n), .ADDR(adr), .WDATA(wd), .WR(wr), .RD(rd),
    .RDATA(rdata), .DMEM_ADDR(dmem_addr), .DMEM_WDATA(dmem_wdata),
    .DMEM_WE(dmem_we), .DMEM_RE(dmem_re), .DMEM_RDATA(dmem_rdata),
    .BANK_SEL(bank_sel), .WORKING(working)
  );

  ida_dmem_model ida_dmem_model_i (
    .CLK(clk), .ADDR(dmem_addr), .WDATA(dmem_wdata), .WE(dmem_we),
    .RE(dmem_re), .RDATA(dmem_rdata)
  );

  // =====
  // clock, 10 ns period
  initial begin
    forever #5 clk = ~clk;
  end

  task automatic close_out;
    if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [11:0] s, input logic [11:0] e);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask

  // one access; memory address checked in the strobe cycle, read data after
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      input logic [11:0] ea, input logic [7:0] er);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    #1 chk(dmem_addr, ea);
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 if (!w) chk({4'h0, rdata}, {4'h0, er});
    @(posedge clk);
  endtask

  // write then read of one register with no gap between the strobes
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] er);
    adr <= a;
    wd <= d;
    wr <= 1'b1;
    rd <= 1'b0;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk({4'h0, rdata}, {4'h0, er});
    @(posedge clk);
  endtask

  // =====
  // watchdog: the whole sequence needs about a hundred cycles
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    close_out();
  end

  // =====
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    xfer(1'b0, 8'h05, 8'h00, 12'h000, 8'h00);
    xfer(1'b1, 8'h05, 8'ha7, 12'h000, 8'h00);
    xfer(1'b0, 8'h05, 8'h00, 12'h000, 8'h07);
    chk({8'h00, bank_sel}, 12'h007);
    xfer(1'b0, 8'hff, 8'h00, 12'h000, 8'h00);
    // each pointer gets its own page so a wrong selection shows up
    for (int i = 0; i < 3; i++) begin
      ha = 8'(3 * i);
      va = 8'(8 * (i + 1));
      p = {4'(i + 1), 8'h00};
      xfer(1'b1, ha, {4'hf, 4'(i + 1)}, 12'h000, 8'h00);
      xfer(1'b0, ha, 8'h00, 12'h000, {4'h0, 4'(i + 1)});
      xfer(1'b1, ha + 8'h01, 8'h00, 12'h000, 8'h00);
      xfer(1'b1, va, 8'h5a, p, 8'h00);
      xfer(1'b0, va, 8'h00, p, 8'h5a);
      xfer(1'b1, va + 8'h01, 8'h11, p, 8'h00);
      xfer(1'b1, va + 8'h01, 8'h22, p + 12'h001, 8'h00);
      xfer(1'b1, va + 8'h02, 8'h33, p + 12'h002, 8'h00);
      xfer(1'b0, va + 8'h02, 8'h00, p + 12'h001, 8'h22);
      xfer(1'b0, va + 8'h03, 8'h00, p + 12'h001, 8'h22);
      xfer(1'b0, va + 8'h03, 8'h00, p + 12'h002, 8'h33);
      xfer(1'b1, 8'h02, 8'hff, 12'h000, 8'h00);
      chk({4'h0, working}, 12'h0ff);
      xfer(1'b0, va + 8'h04, 8'h00, p + 12'h001, 8'h22);
      xfer(1'b0, ha + 8'h01, 8'h00, 12'h000, 8'h02);
    end
    wr_rd(8'h03, 8'hc9, 8'h09);
    wr_rd(8'h07, 8'h6e, 8'h6e);
    close_out();
  end
endmodule
